// *** src/eia_cfg.svh ***
`ifndef EIA_CFG_SVH
`define EIA_CFG_SVH

// Register indices; byte address is four times the index
`define EIA_IDX_STATUS 10'h012
`define EIA_IDX_DBNC 10'h014
`define EIA_IDX_MASK 10'h016
`define EIA_IDX_POL 10'h017
`define EIA_IDX_SEQ 10'h04a
`define EIA_IDX_PIN 10'h04c

// Status, de-bounce and polarity bit of each source
`define EIA_POS_PIN1 0
`define EIA_POS_GPI7 6
`define EIA_POS_GPI8 7
`define EIA_POS_FLL 8
`define EIA_POS_MIC1 9
`define EIA_POS_MIC2 10
`define EIA_POS_TEMP 11
`define EIA_POS_IRQ 12
`define EIA_POS_SEQ 13

// Mask bit of each source
`define EIA_MPOS_PIN1 0
`define EIA_MPOS_SEQ 1
`define EIA_MPOS_GPI7 6
`define EIA_MPOS_GPI8 7
`define EIA_MPOS_FLL 8
`define EIA_MPOS_MIC1 9
`define EIA_MPOS_MIC2 10
`define EIA_MPOS_TEMP 11

`define EIA_EINT_BITS 16'h2fc1
`define EIA_POL_RST 16'h1800
`define EIA_DBNC_RST 16'h0000
`define EIA_MASK_RST 16'h0000
`define EIA_NUM_SRC 8

`endif

// *** src/eia_pkg.sv ***
package eia_pkg;

	typedef enum logic [1:0] {
		EIA_PIN_INPUT = 2'b00,
		EIA_PIN_LOW = 2'b01,
		EIA_PIN_HIGH = 2'b10,
		EIA_PIN_IRQ = 2'b11
	} eia_pin_sel_e;

	// Event inputs from the rest of the codec
	typedef struct packed {
		logic gpi7;
		logic gpi8;
		logic mic1_short;
		logic mic2_short;
		logic fll_lock;
		logic temp_ok;
	} eia_src_s;

	typedef struct packed {
		logic [15:0] status;
		logic [15:0] dbnc;
		logic [15:0] mask;
		logic [15:0] pol;
		eia_pin_sel_e pin_sel;
		logic run;
		logic slow_timeout_clock_prev;
		logic [7:0] trig_prev;
		logic [7:0] filt;
		logic [7:0][1:0] samp;
		logic wr_ok;
		logic [15:0] rdata;
		logic pready;
		logic pslverr;
		logic pin_out;
		logic pin_oe;
		logic irq_pin;
	} eia_state_s;

endpackage : eia_pkg

// *** src/eia_event_interrupt_aggregator.sv ***
// Function
// - Read-only running flag at bit 0 shows sequencer busy (1) or idle (0).
// - Control writes refused while sequencer is busy; host expects no effect.
// - Sequencer busy feeds event logic as a source with de-bounce and polarity.
// - Sequencer event flag bit 13 resets 0, sticks, clears on written 1.
// - De-bounce enable bit 13 filters busy input, only while timeout clock runs.
// - Mask bit 1 set blocks sequencer event from combined interrupt.
// - Polarity bit 13: 0 fires on becoming busy, 1 on becoming idle.
// - Combined interrupt is OR of all unmasked latched event flags.
// - Polarity bit 12, reset 1, makes combined interrupt active low.
// - Combined interrupt readable at status bit 12, read only, polarity applied.
// - Flags latch regardless of mask; mask only gates combined interrupt.
// - Flags set on edges, a held input does not retrigger after clear.
// - While combined interrupt is latched, new trigger events are ignored.
// - Pad input path disabled while the pad drives as output.
// - Polarity 0 triggers on logic 1 input, polarity 1 on logic 0.
// - Event flags in register 12h, always readable, cleared by writing 1.
// - Sources: buttons, accessory detect, clock lock, temperature, sequencer.
// - First general pin can drive constant high or constant low.
//
// Decided for this implementation: the APB slave port.
`include "eia_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module eia_event_interrupt_aggregator
	import eia_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Event sources
	input wire eia_src_s ext_events,
	input wire logic sequencer_running_flag,
	input wire logic slow_timeout_clock,
	// General pin one
	input wire logic general_pin_one_in,
	output logic general_pin_one_out,
	output logic general_pin_one_oe,
	// Combined interrupt level, polarity applied
	output logic combined_irq
);

	eia_state_s st_reg;
	eia_state_s st_next;

	function automatic int stat_pos(input int i);
		case (i)
			0: stat_pos = `EIA_POS_PIN1;
			1: stat_pos = `EIA_POS_GPI7;
			2: stat_pos = `EIA_POS_GPI8;
			3: stat_pos = `EIA_POS_MIC1;
			4: stat_pos = `EIA_POS_MIC2;
			5: stat_pos = `EIA_POS_FLL;
			6: stat_pos = `EIA_POS_TEMP;
			default: stat_pos = `EIA_POS_SEQ;
		endcase
	endfunction : stat_pos

	function automatic int mask_pos(input int i);
		case (i)
			0: mask_pos = `EIA_MPOS_PIN1;
			1: mask_pos = `EIA_MPOS_GPI7;
			2: mask_pos = `EIA_MPOS_GPI8;
			3: mask_pos = `EIA_MPOS_MIC1;
			4: mask_pos = `EIA_MPOS_MIC2;
			5: mask_pos = `EIA_MPOS_FLL;
			6: mask_pos = `EIA_MPOS_TEMP;
			default: mask_pos = `EIA_MPOS_SEQ;
		endcase
	endfunction : mask_pos

	function automatic logic reg_hit(input logic [11:0] a);
		logic [9:0] idx;
		idx = a[11:2];
		reg_hit = (a[1:0] == 2'b00) && (idx == `EIA_IDX_STATUS || idx == `EIA_IDX_DBNC ||
			idx == `EIA_IDX_MASK || idx == `EIA_IDX_POL || idx == `EIA_IDX_SEQ ||
			idx == `EIA_IDX_PIN);
	endfunction : reg_hit

	logic [7:0] src_raw;
	logic [7:0] filt_eff;
	logic [7:0] trig;
	logic pin_in_eff;
	logic tick;
	logic irq_raw;
	logic irq_level;
	logic access;
	logic done;

	// Input path gated off while the pad drives, no loop through the pad
	assign pin_in_eff = general_pin_one_in & ~st_reg.pin_oe;
	// Five source classes gathered into one vector
	assign src_raw = {sequencer_running_flag, ext_events.temp_ok, ext_events.fll_lock,
		ext_events.mic2_short, ext_events.mic1_short, ext_events.gpi8, ext_events.gpi7,
		pin_in_eff};
	assign tick = slow_timeout_clock & ~st_reg.slow_timeout_clock_prev;
	assign access = psel & penable;
	assign done = access & st_reg.pready;

	always_comb begin
		logic [9:0] idx;
		logic [15:0] wd;
		int sp;
		int mp;
		sp = 0;
		mp = 0;
		idx = paddr[11:2];
		wd = pwdata[15:0];
		st_next = st_reg;
		irq_raw = 1'b0;
		filt_eff = '0;
		trig = '0;
		st_next.slow_timeout_clock_prev = slow_timeout_clock;
		st_next.run = sequencer_running_flag;

		for (int i = 0; i < `EIA_NUM_SRC; i++) begin
			sp = stat_pos(i);
			mp = mask_pos(i);
			// Flags gate the combined interrupt only through the mask
			irq_raw = irq_raw | (st_reg.status[sp] & ~st_reg.mask[mp]);
		end
		irq_level = irq_raw ^ st_reg.pol[`EIA_POS_IRQ];

		// Register access: clears first so a same-cycle set wins
		if (done && st_reg.wr_ok && pwrite) begin
			unique case (idx)
				`EIA_IDX_STATUS: st_next.status = st_reg.status & ~(wd & `EIA_EINT_BITS);
				`EIA_IDX_DBNC: st_next.dbnc = wd;
				`EIA_IDX_MASK: st_next.mask = wd;
				`EIA_IDX_POL: st_next.pol = wd;
				`EIA_IDX_PIN: st_next.pin_sel = eia_pin_sel_e'(wd[1:0]);
				default: st_next.pin_sel = st_reg.pin_sel;
			endcase
		end

		for (int i = 0; i < `EIA_NUM_SRC; i++) begin
			sp = stat_pos(i);
			// Filter holds still when the timeout clock is stopped
			if (st_reg.dbnc[sp]) begin
				if (tick) begin
					st_next.samp[i] = {st_reg.samp[i][0], src_raw[i]};
					if (st_reg.samp[i][1] == st_reg.samp[i][0] &&
						st_reg.samp[i][0] == src_raw[i]) begin
						st_next.filt[i] = src_raw[i];
					end
				end
				filt_eff[i] = st_reg.filt[i];
			end else begin
				st_next.filt[i] = src_raw[i];
				st_next.samp[i] = {src_raw[i], src_raw[i]};
				filt_eff[i] = src_raw[i];
			end
			trig[i] = filt_eff[i] ^ st_reg.pol[sp];
			// Edge only, and nothing new while the combined interrupt stands
			if (trig[i] && !st_reg.trig_prev[i] && !irq_raw) begin
				st_next.status[sp] = 1'b1;
			end
		end
		st_next.trig_prev = trig;

		// Answer is prepared in the first access cycle, completes in the second
		st_next.pready = access & ~st_reg.pready;
		if (access && !st_reg.pready) begin
			// Writes during a running sequence are refused with an error
			st_next.wr_ok = reg_hit(paddr) & ~(pwrite & sequencer_running_flag);
			st_next.pslverr = ~reg_hit(paddr) | (pwrite & sequencer_running_flag);
			unique case (idx)
				`EIA_IDX_STATUS: begin
					st_next.rdata = st_reg.status & `EIA_EINT_BITS;
					st_next.rdata[`EIA_POS_IRQ] = irq_level;
				end
				`EIA_IDX_DBNC: st_next.rdata = st_reg.dbnc;
				`EIA_IDX_MASK: st_next.rdata = st_reg.mask;
				`EIA_IDX_POL: st_next.rdata = st_reg.pol;
				`EIA_IDX_SEQ: st_next.rdata = {15'h0000, st_reg.run};
				`EIA_IDX_PIN: st_next.rdata = {14'h0000, st_reg.pin_sel};
				default: st_next.rdata = 16'h0000;
			endcase
			if (!reg_hit(paddr) || pwrite) begin
				st_next.rdata = 16'h0000;
			end
		end else if (done) begin
			st_next.pslverr = 1'b0;
			st_next.wr_ok = 1'b0;
			st_next.rdata = 16'h0000;
		end

		unique case (st_reg.pin_sel)
			EIA_PIN_INPUT: begin
				st_next.pin_oe = 1'b0;
				st_next.pin_out = 1'b0;
			end
			EIA_PIN_LOW: begin
				st_next.pin_oe = 1'b1;
				st_next.pin_out = 1'b0;
			end
			EIA_PIN_HIGH: begin
				st_next.pin_oe = 1'b1;
				st_next.pin_out = 1'b1;
			end
			EIA_PIN_IRQ: begin
				st_next.pin_oe = 1'b1;
				st_next.pin_out = irq_level;
			end
		endcase
		st_next.irq_pin = irq_level;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.pol <= `EIA_POL_RST;
			st_reg.dbnc <= `EIA_DBNC_RST;
			st_reg.mask <= `EIA_MASK_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = {16'h0000, st_reg.rdata};
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign general_pin_one_out = st_reg.pin_out;
	assign general_pin_one_oe = st_reg.pin_oe;
	assign combined_irq = st_reg.irq_pin;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	run_flag_a: assert property (
		sequencer_running_flag |=> st_reg.run ##1 (st_reg.run == $past(sequencer_running_flag))
	) else $error("Running flag does not follow sequencer");

	write_lockout_a: assert property (
		(access && !st_reg.pready && pwrite && sequencer_running_flag) ##1 done |=>
			$stable(st_reg.mask) && $stable(st_reg.pol) && $stable(st_reg.dbnc) && pslverr == 1'b0
	) else $error("Write took effect while sequencer busy");

	seq_flag_hold_a: assert property (
		st_reg.status[`EIA_POS_SEQ] && !(done && pwrite) |=> st_reg.status[`EIA_POS_SEQ]
	) else $error("Sequencer event flag dropped without clear");

	seq_mask_a: assert property (
		st_reg.mask[`EIA_MPOS_SEQ] && (st_reg.status & `EIA_EINT_BITS) == 16'h2000 |-> !irq_raw
	) else $error("Masked sequencer event reached combined interrupt");

	busy_edge_a: assert property (
		!st_reg.dbnc[`EIA_POS_SEQ] && !st_reg.pol[`EIA_POS_SEQ] && !st_reg.trig_prev[7] &&
			sequencer_running_flag && !irq_raw |=> st_reg.status[`EIA_POS_SEQ]
	) else $error("Busy edge did not set sequencer event flag");

	irq_polarity_a: assert property (
		presetn |=> combined_irq == ($past(irq_raw) ^ $past(st_reg.pol[`EIA_POS_IRQ]))
	) else $error("Combined interrupt level wrong for its polarity");

	irq_freeze_a: assert property (
		irq_raw && !(done && pwrite) |=> (st_reg.status & ~$past(st_reg.status)) == 16'h0000
	) else $error("New event latched while combined interrupt stands");

	debounce_hold_a: assert property (
		st_reg.dbnc[`EIA_POS_SEQ] && !tick |=> $stable(st_reg.filt[7])
	) else $error("De-bounced input changed without timeout clock edge");

	pad_gate_a: assert property (
		general_pin_one_oe && !st_reg.dbnc[`EIA_POS_PIN1] |-> trig[0] == st_reg.pol[`EIA_POS_PIN1]
	) else $error("Pad input path open while driving");

	pin_level_a: assert property (
		st_reg.pin_sel == EIA_PIN_HIGH |=> general_pin_one_oe && general_pin_one_out
	) else $error("Pin does not drive constant high");

	// Bus answers to refused and read requests
	busy_refuse_a: assert property (
		access && !st_reg.pready && pwrite && sequencer_running_flag |=> pready && pslverr
	) else $error("Write during running sequence not refused");

	busy_noload_a: assert property (
		access && !st_reg.pready && pwrite && sequencer_running_flag |=> !st_reg.wr_ok
	) else $error("Write during running sequence armed");

	status_read_a: assert property (
		access && !st_reg.pready && !pwrite && paddr == {`EIA_IDX_STATUS, 2'b00} |=>
			prdata[`EIA_POS_IRQ] == $past(irq_level) &&
			prdata[`EIA_POS_SEQ] == $past(st_reg.status[`EIA_POS_SEQ])
	) else $error("Status read does not show flags and interrupt");

	run_read_a: assert property (
		access && !st_reg.pready && !pwrite && paddr == {`EIA_IDX_SEQ, 2'b00} |=>
			prdata == {31'h0000_0000, $past(st_reg.run)}
	) else $error("Running flag read wrong");

	// Flag clearing and the read-only interrupt bit
	flag_clear_a: assert property (
		done && st_reg.wr_ok && pwrite && paddr == {`EIA_IDX_STATUS, 2'b00} &&
			pwdata[`EIA_POS_SEQ] && !trig[7] |=> !st_reg.status[`EIA_POS_SEQ]
	) else $error("Written one did not clear sequencer event flag");

	irq_bit_ro_a: assert property (
		(st_reg.status & ~(`EIA_EINT_BITS)) == 16'h0000
	) else $error("Status bit outside the event flags was set");

	// Edge capture and de-bounce filter of the sequencer source
	masked_latch_a: assert property (
		!st_reg.dbnc[`EIA_POS_SEQ] && !st_reg.pol[`EIA_POS_SEQ] &&
			st_reg.mask[`EIA_MPOS_SEQ] && !st_reg.trig_prev[7] &&
			sequencer_running_flag && !irq_raw |=> st_reg.status[`EIA_POS_SEQ]
	) else $error("Masked sequencer event was not latched");

	idle_edge_a: assert property (
		!st_reg.dbnc[`EIA_POS_SEQ] && st_reg.pol[`EIA_POS_SEQ] && !st_reg.trig_prev[7] &&
			!sequencer_running_flag && !irq_raw |=> st_reg.status[`EIA_POS_SEQ]
	) else $error("Idle edge did not set sequencer event flag");

	held_input_a: assert property (
		st_reg.trig_prev[7] && trig[7] && !st_reg.status[`EIA_POS_SEQ] |=>
			!st_reg.status[`EIA_POS_SEQ]
	) else $error("Held sequencer input retriggered");

	debounce_off_a: assert property (
		!st_reg.dbnc[`EIA_POS_SEQ] |=> st_reg.filt[7] == $past(sequencer_running_flag)
	) else $error("Unfiltered sequencer input not passed through");

	debounce_pass_a: assert property (
		st_reg.dbnc[`EIA_POS_SEQ] && tick && st_reg.samp[7] == {2{sequencer_running_flag}} |=>
			st_reg.filt[7] == $past(sequencer_running_flag)
	) else $error("Stable sequencer input not passed by filter");

	debounce_wait_a: assert property (
		st_reg.dbnc[`EIA_POS_SEQ] && st_reg.samp[7][1] != st_reg.samp[7][0] |=>
			$stable(st_reg.filt[7])
	) else $error("Filter passed an input that was not yet stable");

	// Level sense of the other sources
	low_level_a: assert property (
		!st_reg.dbnc[`EIA_POS_TEMP] && st_reg.pol[`EIA_POS_TEMP] && !ext_events.temp_ok &&
			!st_reg.trig_prev[6] && !irq_raw |=> st_reg.status[`EIA_POS_TEMP]
	) else $error("Low level did not trigger with polarity one");

	high_level_a: assert property (
		!st_reg.dbnc[`EIA_POS_FLL] && !st_reg.pol[`EIA_POS_FLL] && ext_events.fll_lock &&
			!st_reg.trig_prev[5] && !irq_raw |=> st_reg.status[`EIA_POS_FLL]
	) else $error("High level did not trigger with polarity zero");

	// Combined interrupt as OR of unmasked flags
	irq_or_a: assert property (
		st_reg.status[`EIA_POS_TEMP] && !st_reg.mask[`EIA_MPOS_TEMP] |-> irq_raw
	) else $error("Unmasked flag missing from combined interrupt");

	irq_none_a: assert property (
		(st_reg.status & `EIA_EINT_BITS) == 16'h0000 |-> !irq_raw
	) else $error("Combined interrupt without any flag");

	mask_pass_a: assert property (
		st_reg.status[`EIA_POS_SEQ] && !st_reg.mask[`EIA_MPOS_SEQ] |-> irq_raw
	) else $error("Unmasked sequencer event blocked");

	// Pad drive
	pin_low_a: assert property (
		st_reg.pin_sel == EIA_PIN_LOW |=> general_pin_one_oe && !general_pin_one_out
	) else $error("Pin does not drive constant low");

	pad_drive_a: assert property (
		st_reg.pin_sel != EIA_PIN_INPUT |=> general_pin_one_oe
	) else $error("Pad not driving in an output mode");

	pin_irq_a: assert property (
		st_reg.pin_sel == EIA_PIN_IRQ |=> general_pin_one_out == $past(irq_level)
	) else $error("Pin does not carry the combined interrupt");

endmodule : eia_event_interrupt_aggregator

`default_nettype wire

// *** dv/eia_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module eia_host_model (
	// Clock
	input wire logic pclk,
	// APB master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end

	// Released address and data go inverted so stale values never look valid
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err, output logic tmo);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr; // Caller never assumes a refused write landed
		tmo = (n >= 50);
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : eia_host_model

`default_nettype wire

// *** dv/event_interrupt_aggregator_bench.sv ***
`timescale 1ns/100ps
`default_nettype none

module event_interrupt_aggregator_bench;
	import eia_pkg::*;
	localparam logic [11:0] A_ST = 12'h048;
	localparam logic [11:0] A_DB = 12'h050;
	localparam logic [11:0] A_MK = 12'h058;
	localparam logic [11:0] A_PL = 12'h05c;
	localparam logic [11:0] A_SQ = 12'h128;
	localparam logic [11:0] A_PN = 12'h130;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, busy, stc;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [6:0] src_v;
	logic pin_out, pin_oe, combined_irq;
	int n_fail = 0;
	int checks = 0;
	int pos [7] = '{11, 8, 10, 9, 7, 6, 0};

	always #5 pclk = ~pclk;

	eia_event_interrupt_aggregator dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_events(eia_src_s'(src_v[5:0])), .sequencer_running_flag(busy),
		.slow_timeout_clock(stc), .general_pin_one_in(src_v[6]),
		.general_pin_one_out(pin_out), .general_pin_one_oe(pin_oe),
		.combined_irq(combined_irq));

	eia_host_model host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	task automatic results();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// Writes compare only the error flag
	task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic ee, input string nm);
		logic [31:0] rd;
		logic err, tmo;
		host_u.xfer(wr, a, d, rd, err, tmo);
		if (tmo) begin
			n_fail++;
			results();
		end
		if (!wr) begin
			chk(nm, rd, e);
		end
		chk({nm, " err"}, {31'h0, err}, {31'h0, ee});
	endtask : acc

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	task automatic irq(input logic e, input string nm);
		cyc(3);
		chk(nm, {31'h0, combined_irq}, {31'h0, e});
	endtask : irq

	task automatic bpulse();
		busy <= 1'b1;
		cyc(4);
		busy <= 1'b0;
		cyc(4);
	endtask : bpulse

	task automatic tick(input int n);
		repeat (n) begin
			stc <= 1'b1;
			cyc(3);
			stc <= 1'b0;
			cyc(3);
		end
	endtask : tick

	initial begin
		busy = 1'b0;
		stc = 1'b0;
		src_v = 7'h01;
		cyc(12);
		presetn <= 1'b1;
		cyc(2);
		acc(0, A_ST, 0, 32'h0000_1000, 0, "status");
		acc(0, A_DB, 0, 32'h0000_0000, 0, "dbnc");
		acc(0, A_MK, 0, 32'h0000_0000, 0, "mask");
		acc(0, A_PL, 0, 32'h0000_1800, 0, "pol");
		acc(0, A_SQ, 0, 32'h0000_0000, 0, "seq");
		acc(0, 12'h004, 0, 32'h0000_0000, 1, "unmapped");
		$display("test reset done");
		busy <= 1'b1;
		irq(0, "irq busy");
		acc(0, A_SQ, 0, 32'h0000_0001, 0, "seq busy");
		acc(1, A_MK, 32'h0000_0002, 0, 1, "locked wr");
		busy <= 1'b0;
		cyc(2);
		acc(0, A_MK, 0, 32'h0000_0000, 0, "mask kept");
		acc(0, A_ST, 0, 32'h0000_2000, 0, "seq flag");
		acc(1, A_ST, 32'h0000_3000, 0, 0, "clr");
		acc(0, A_ST, 0, 32'h0000_1000, 0, "cleared");
		irq(1, "irq idle");
		acc(1, A_MK, 32'h0000_0002, 0, 0, "mask");
		bpulse();
		irq(1, "irq masked");
		acc(0, A_ST, 0, 32'h0000_3000, 0, "masked flag");
		acc(1, A_ST, 32'h0000_2000, 0, 0, "clr");
		acc(1, A_MK, 0, 0, 0, "unmask");
		$display("test sequencer done");
		// Polarity set before the sequence, its own edge cleared away
		acc(1, A_PL, 32'h0000_3800, 0, 0, "pol");
		acc(1, A_ST, 32'h0000_2000, 0, 0, "clr");
		busy <= 1'b1;
		cyc(4);
		acc(0, A_ST, 0, 32'h0000_1000, 0, "no busy trig");
		busy <= 1'b0;
		cyc(3);
		acc(0, A_ST, 0, 32'h0000_2000, 0, "idle trig");
		acc(1, A_PL, 32'h0000_0800, 0, 0, "pol");
		irq(1, "irq high");
		acc(0, A_ST, 0, 32'h0000_3000, 0, "irq bit");
		acc(1, A_ST, 32'h0000_2000, 0, 0, "clr");
		irq(0, "irq high idle");
		acc(1, A_PL, 32'h0000_1800, 0, 0, "pol");
		$display("test polarity done");
		for (int i = 0; i < 7; i++) begin
			src_v[i] <= ~src_v[i];
			cyc(2);
			src_v[i] <= ~src_v[i];
			cyc(2);
			acc(0, A_ST, 0, 32'h0000_0001 << pos[i], 0, "source");
			acc(1, A_ST, 32'h0000_0001 << pos[i], 0, 0, "clr");
		end
		src_v[5] <= 1'b1;
		cyc(3);
		bpulse();
		acc(0, A_ST, 0, 32'h0000_0040, 0, "latched");
		acc(1, A_ST, 32'h0000_0040, 0, 0, "clr");
		cyc(3);
		acc(0, A_ST, 0, 32'h0000_1000, 0, "held");
		src_v[5] <= 1'b0;
		$display("test sources done");
		acc(1, A_PN, 32'h0000_0002, 0, 0, "pin");
		cyc(2);
		chk("pin high", {30'h0, pin_oe, pin_out}, 32'h0000_0003);
		src_v[6] <= 1'b1;
		cyc(3);
		acc(0, A_ST, 0, 32'h0000_1000, 0, "pad gated");
		acc(1, A_PN, 32'h0000_0001, 0, 0, "pin");
		src_v[6] <= 1'b0;
		cyc(2);
		chk("pin low", {30'h0, pin_oe, pin_out}, 32'h0000_0002);
		acc(1, A_PN, 32'h0000_0003, 0, 0, "pin");
		cyc(2);
		chk("pin irq", {30'h0, pin_oe, pin_out}, 32'h0000_0003);
		acc(1, A_PN, 0, 0, 0, "pin");
		cyc(2);
		chk("pin in", {31'h0, pin_oe}, 32'h0000_0000);
		$display("test pin done");
		acc(1, A_DB, 32'h0000_2000, 0, 0, "dbnc");
		busy <= 1'b1;
		irq(1, "frozen");
		tick(2);
		irq(1, "short");
		tick(2);
		irq(0, "filtered");
		busy <= 1'b0;
		tick(4);
		acc(0, A_ST, 0, 32'h0000_2000, 0, "db flag");
		$display("test debounce done");
		results();
	end
endmodule : event_interrupt_aggregator_bench

`default_nettype wire
